/* File: dpll_pin_control_status.sv */
`timescale 1ns/1ns
// pin control and status logic of the transmit loop and synthesizer 1

////////////////////////////////////////////////////////////////////////////////
// How it works
// - a low level on reset_n holds the block in reset, except the pin synchronisers
// - hitless enable high lets the loop switch references hitlessly
// - hitless enable low disables it and realigns phase to selected reference
// - a software register can override the hitless enable pin
// - mode pins sampled during reset give the default loop mode
// - after reset, mode follows pin changes or writes to register 0x1F
// - each differential driver is enabled by its own pin, else tristated
// - lock goes high when loop is frequency and phase locked
// - hold goes high in holdover mode, or in automatic mode when the loop enters holdover
// - ref_out is a plain registered copy of the receive selector output
// - synth 1 clock 0 is 2 kHz or n x 8 kHz to 100 MHz, default 1.544 MHz
// - synth 1 clock 1 is multiple or division of clock 0, default 3.088 MHz
// - synth 1 frame pulse 1 style is configurable, default 8 kHz
module dpll_pin_control_status
    import dpll_pin_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hitless_switch_enable,
    input wire logic [1:0] mode_pin,
    input wire logic diff_driver0_enable,
    input wire logic diff_driver1_enable,
    input wire loop_status_t loop_status,
    input wire logic rx_ref_selected,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output tx_mode_t tx_mode,
    output logic hitless_active,
    output logic phase_realign,
    output logic lock,
    output logic hold,
    output logic ref_out,
    output logic [1:0] diff_driver_oe_n,
    output synth_cfg_t synth_cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, left out of reset so pins are seen during reset

    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    wire logic [4:0] pin_raw;

    assign pin_raw = {diff_driver1_enable, diff_driver0_enable, mode_pin,
                      hitless_switch_enable};

    always_ff @(posedge clk) begin
        pin_meta_reg <= pin_raw;
        pin_sync_reg <= pin_meta_reg;
    end

    wire logic hs_pin;
    wire tx_mode_t mode_pin_s;
    wire logic [1:0] diff_en_s;

    assign hs_pin = pin_sync_reg[0];
    assign mode_pin_s = pin_sync_reg[2:1];
    assign diff_en_s = pin_sync_reg[4:3];

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    wire logic wr_mode;
    wire logic wr_hitless;
    wire logic wr_clk0_lo;
    wire logic wr_clk0_hi;
    wire logic wr_clk1;
    wire logic wr_fp1;

    assign wr_mode = reg_wr && (reg_addr == TX_MODE_SEL_ADDR);
    assign wr_hitless = reg_wr && (reg_addr == HITLESS_CTRL_ADDR);
    assign wr_clk0_lo = reg_wr && (reg_addr == CLK0_LO_ADDR);
    assign wr_clk0_hi = reg_wr && (reg_addr == CLK0_HI_ADDR);
    assign wr_clk1 = reg_wr && (reg_addr == CLK1_CFG_ADDR);
    assign wr_fp1 = reg_wr && (reg_addr == FP1_CFG_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // transmit loop mode

    tx_mode_t mode_reg;
    tx_mode_t mode_next;
    tx_mode_t mode_prev_reg;
    wire logic mode_pin_changed;

    assign mode_pin_changed = (mode_pin_s != mode_prev_reg);

    // register write wins over a pin change in the same cycle
    always_comb begin
        if (wr_mode) begin
            mode_next = tx_mode_t'(reg_wdata[1:0]);
        end else if (mode_pin_changed) begin
            mode_next = mode_pin_s;
        end else begin
            mode_next = mode_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_reg <= mode_pin_s;
            mode_prev_reg <= mode_pin_s;
        end else begin
            mode_reg <= mode_next;
            mode_prev_reg <= mode_pin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hitless switching control

    logic [1:0] hs_ctrl_reg;
    wire logic hs_eff;
    wire logic realign_next;

    // software override selects the register value instead of the pin
    assign hs_eff = hs_ctrl_reg[HS_SW_SEL_BIT] ? hs_ctrl_reg[HS_SW_VAL_BIT]
                                               : hs_pin;
    assign realign_next = loop_status.ref_switched && !hs_eff;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hs_ctrl_reg <= 2'h0;
        end else if (wr_hitless) begin
            hs_ctrl_reg <= reg_wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // synthesizer configuration

    // true when clock 1 stays within 2 kHz .. 100 MHz
    function automatic logic clk1_ok(input logic [13:0] mult,
                                     input logic div,
                                     input logic [6:0] factor);
        logic [15:0] f0;
        logic [22:0] prod;
        begin
            f0 = (mult == 14'h0) ? 16'h0001 : {mult, 2'b00};
            prod = 23'(f0) * 23'(factor);
            if (factor == 7'h0) begin
                clk1_ok = 1'b0;
            end else if (div) begin
                clk1_ok = (f0 >= 16'(factor));
            end else begin
                clk1_ok = (prod <= FREQ_MAX_2K);
            end
        end
    endfunction

    synth_cfg_t cfg_reg;
    logic [7:0] clk0_lo_stage_reg;
    wire logic [13:0] clk0_new;
    wire logic clk0_new_ok;
    wire logic clk1_new_ok;

    assign clk0_new = {reg_wdata[5:0], clk0_lo_stage_reg};
    assign clk0_new_ok = ({7'h0, clk0_new, 2'b00} <= FREQ_MAX_2K)
                         && clk1_ok(clk0_new, cfg_reg.clk1_div, cfg_reg.clk1_factor);
    assign clk1_new_ok = clk1_ok(cfg_reg.clk0_mult, reg_wdata[CLK1_DIV_BIT],
                                 reg_wdata[6:0]);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clk0_lo_stage_reg <= CLK0_MULT_RESET[7:0];
        end else if (wr_clk0_lo) begin
            clk0_lo_stage_reg <= reg_wdata;
        end
    end

    // out-of-range settings are ignored and the old setting kept
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_reg.clk0_mult <= CLK0_MULT_RESET;
            cfg_reg.clk1_div <= CLK1_DIV_RESET;
            cfg_reg.clk1_factor <= CLK1_FACTOR_RESET;
            cfg_reg.fp1_pol <= FP1_POL_RESET;
            cfg_reg.fp1_width <= FP1_WIDTH_RESET;
            cfg_reg.fp1_rate <= FP1_RATE_8K;
        end else begin
            if (wr_clk0_hi && clk0_new_ok) begin
                cfg_reg.clk0_mult <= clk0_new;
            end
            if (wr_clk1 && clk1_new_ok) begin
                cfg_reg.clk1_div <= reg_wdata[CLK1_DIV_BIT];
                cfg_reg.clk1_factor <= reg_wdata[6:0];
            end
            if (wr_fp1) begin
                cfg_reg.fp1_pol <= reg_wdata[FP1_POL_BIT];
                cfg_reg.fp1_width <= reg_wdata[FP1_WIDTH_LSB +: 2];
                cfg_reg.fp1_rate <= reg_wdata[FP1_RATE_LSB +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status outputs

    wire logic lock_next;
    wire logic hold_next;

    assign lock_next = loop_status.freq_locked && loop_status.phase_locked;
    assign hold_next = (mode_reg == MODE_HOLDOVER)
                       || ((mode_reg == MODE_AUTOMATIC)
                           && loop_status.in_holdover);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_mode <= MODE_AUTOMATIC;
            hitless_active <= 1'b0;
            phase_realign <= 1'b0;
            lock <= 1'b0;
            hold <= 1'b0;
            ref_out <= 1'b0;
            diff_driver_oe_n <= 2'h3;
            synth_cfg <= '0;
        end else begin
            tx_mode <= mode_reg;
            hitless_active <= hs_eff;
            phase_realign <= realign_next;
            lock <= lock_next;
            hold <= hold_next;
            ref_out <= rx_ref_selected;
            diff_driver_oe_n <= ~diff_en_s;
            synth_cfg <= cfg_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, answer one cycle after reg_rd

    logic [DATA_W-1:0] rdata_next;
    wire logic [DATA_W-1:0] status_word;

    assign status_word = {1'b0, diff_en_s[1], diff_en_s[0], mode_reg,
                          hs_eff, hold, lock};

    always_comb begin
        case (reg_addr)
            TX_MODE_SEL_ADDR: rdata_next = {6'h0, mode_reg};
            HITLESS_CTRL_ADDR: rdata_next = {6'h0, hs_ctrl_reg};
            CLK0_LO_ADDR: rdata_next = cfg_reg.clk0_mult[7:0];
            CLK0_HI_ADDR: rdata_next = {2'h0, cfg_reg.clk0_mult[13:8]};
            CLK1_CFG_ADDR: rdata_next = {cfg_reg.clk1_div, cfg_reg.clk1_factor};
            FP1_CFG_ADDR: rdata_next = {3'h0, cfg_reg.fp1_pol, cfg_reg.fp1_width,
                                        cfg_reg.fp1_rate};
            STATUS_ADDR: rdata_next = status_word;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

endmodule

/* File: dpll_pin_pkg.sv */
// constants and types for the dpll pin control and status block
package dpll_pin_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [6:0] TX_MODE_SEL_ADDR = 7'h1F;
    localparam logic [6:0] HITLESS_CTRL_ADDR = 7'h20;
    localparam logic [6:0] CLK0_LO_ADDR = 7'h21;
    localparam logic [6:0] CLK0_HI_ADDR = 7'h22;
    localparam logic [6:0] CLK1_CFG_ADDR = 7'h23;
    localparam logic [6:0] FP1_CFG_ADDR = 7'h24;
    localparam logic [6:0] STATUS_ADDR = 7'h25;

    // transmit loop mode encoding, shared by pins and register
    typedef logic [1:0] tx_mode_t;
    localparam tx_mode_t MODE_AUTOMATIC = 2'h0;
    localparam tx_mode_t MODE_NORMAL = 2'h1;
    localparam tx_mode_t MODE_HOLDOVER = 2'h2;
    localparam tx_mode_t MODE_FREERUN = 2'h3;

    // field positions
    localparam int HS_SW_SEL_BIT = 0;
    localparam int HS_SW_VAL_BIT = 1;
    localparam int CLK1_DIV_BIT = 7;
    localparam int FP1_RATE_LSB = 0;
    localparam int FP1_WIDTH_LSB = 2;
    localparam int FP1_POL_BIT = 4;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_HOLD_BIT = 1;
    localparam int ST_HITLESS_BIT = 2;
    localparam int ST_MODE_LSB = 3;
    localparam int ST_DIFF0_BIT = 5;
    localparam int ST_DIFF1_BIT = 6;

    // synthesizer limits and defaults, frequencies in 2 kHz units
    localparam logic [13:0] CLK0_MULT_RESET = 14'h00C1;
    localparam logic [22:0] FREQ_MAX_2K = 23'h00C350;
    localparam logic [6:0] CLK1_FACTOR_RESET = 7'h02;
    localparam logic CLK1_DIV_RESET = 1'b0;
    localparam logic [1:0] FP1_RATE_8K = 2'h0;
    localparam logic [1:0] FP1_WIDTH_RESET = 2'h0;
    localparam logic FP1_POL_RESET = 1'b0;

    // least reset pulse width
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESET_MIN_NS = 300;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [13:0] clk0_mult;
        logic clk1_div;
        logic [6:0] clk1_factor;
        logic fp1_pol;
        logic [1:0] fp1_width;
        logic [1:0] fp1_rate;
    } synth_cfg_t;

    typedef struct packed {
        logic freq_locked;
        logic phase_locked;
        logic in_holdover;
        logic ref_switched;
    } loop_status_t;
endpackage

/* File: board_ctrl.sv */
`timescale 1ns/1ns
// board controller model driving the control pins
module board_ctrl
    import dpll_pin_pkg::*;
(
    input wire logic clk,
    input wire logic rst_req,
    input wire logic want_hs,
    input wire logic [1:0] want_mode,
    input wire logic want_d0,
    input wire logic want_d1,
    output logic reset_n,
    output logic hitless_switch_enable,
    output logic [1:0] mode_pin,
    output logic diff_driver0_enable,
    output logic diff_driver1_enable
);
    int low_cnt = 0;
    initial begin
        {reset_n, hitless_switch_enable, mode_pin, diff_driver0_enable, diff_driver1_enable} = '0;
    end
    always @(posedge clk) begin
        low_cnt <= rst_req ? 0 : (low_cnt < 8 ? low_cnt + 1 : low_cnt);
        reset_n <= #1 (low_cnt >= 7) && !rst_req;
        hitless_switch_enable <= #1 want_hs;
        mode_pin <= #1 want_mode;
        {diff_driver0_enable, diff_driver1_enable} <= #1 {want_d0, want_d1};
    end
endmodule

/* File: dpll_pin_control_status_assertions.sv */
`timescale 1ns/1ns
// assertion checker for the dpll pin control and status block
module dpll_pin_control_status_assertions
    import dpll_pin_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] mode_pin,
    input wire logic diff_driver0_enable,
    input wire loop_status_t loop_status,
    input wire logic rx_ref_selected,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire tx_mode_t tx_mode,
    input wire logic hitless_active,
    input wire logic phase_realign,
    input wire logic lock,
    input wire logic hold,
    input wire logic ref_out,
    input wire logic [1:0] diff_driver_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_pins_quiet;
        $stable(mode_pin)[*4];
    endsequence
    sequence s_mode_write;
        s_pins_quiet ##0 (reg_wr && reg_addr == TX_MODE_SEL_ADDR);
    endsequence
    property p_reset_values;
        disable iff (1'b0) !reset_n |=> diff_driver_oe_n == 2'h3 && !lock && !hold && !ref_out;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("outputs not reset");
    property p_mode_default;
        disable iff (1'b0) s_pins_quiet ##0 !reset_n ##1 reset_n |=> tx_mode == $past(mode_pin, 2);
    endproperty
    a_mode_default: assert property (p_mode_default) else $error("mode not sampled");
    property p_mode_write;
        s_mode_write |-> ##2 tx_mode == $past(reg_wdata[1:0], 2);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");
    property p_mode_pins;
        $changed(mode_pin) ##1 ($stable(mode_pin) && !reg_wr)[*5] |-> tx_mode == mode_pin;
    endproperty
    a_mode_pins: assert property (p_mode_pins) else $error("mode pins ignored");
    property p_lock;
        1'b1 |=> lock == $past(loop_status.freq_locked && loop_status.phase_locked);
    endproperty
    a_lock: assert property (p_lock) else $error("lock wrong");
    property p_hold;
        tx_mode == MODE_HOLDOVER |-> hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold missing");
    property p_ref_copy;
        1'b1 |=> ref_out == $past(rx_ref_selected);
    endproperty
    a_ref_copy: assert property (p_ref_copy) else $error("ref_out wrong");
    property p_realign;
        loop_status.ref_switched ##1 $stable(hitless_active) |-> phase_realign == !hitless_active;
    endproperty
    a_realign: assert property (p_realign) else $error("realign wrong");
    property p_diff_on;
        diff_driver0_enable[*5] |-> !diff_driver_oe_n[0];
    endproperty
    a_diff_on: assert property (p_diff_on) else $error("driver not on");
endmodule
bind dpll_pin_control_status dpll_pin_control_status_assertions chk_i (.clk, .reset_n,
    .mode_pin, .diff_driver0_enable, .loop_status, .rx_ref_selected, .reg_addr, .reg_wdata,
    .reg_wr, .tx_mode, .hitless_active, .phase_realign, .lock, .hold, .ref_out,
    .diff_driver_oe_n);

/* File: tb.sv */
`timescale 1ns/1ns
// self-checking bench for the dpll pin control and status block
module tb;
    import dpll_pin_pkg::*;
    logic clk = 1'b0;
    logic rst_req = 1'b0, want_hs = 1'b1, want_d0 = 1'b1, want_d1 = 1'b0;
    logic [1:0] want_mode = MODE_HOLDOVER;
    logic reset_n, hitless_switch_enable, diff_driver0_enable, diff_driver1_enable;
    logic [1:0] mode_pin;
    loop_status_t loop_status = '0;
    logic rx_ref_selected = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    tx_mode_t tx_mode;
    logic hitless_active, phase_realign, lock, hold, ref_out;
    logic [1:0] diff_driver_oe_n;
    synth_cfg_t synth_cfg;
    int fail_count = 0, check_count = 0;
    always #25 clk = ~clk;
    board_ctrl bc (.clk, .rst_req, .want_hs, .want_mode, .want_d0, .want_d1, .reset_n,
        .hitless_switch_enable, .mode_pin, .diff_driver0_enable, .diff_driver1_enable);
    dpll_pin_control_status dut (.clk, .reset_n, .hitless_switch_enable, .mode_pin,
        .diff_driver0_enable, .diff_driver1_enable, .loop_status, .rx_ref_selected,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_mode, .hitless_active,
        .phase_realign, .lock, .hold, .ref_out, .diff_driver_oe_n, .synth_cfg);
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        cyc(1);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        cyc(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        cyc(1);
        {reg_rd, reg_addr} = {1'b1, a};
        cyc(1);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic pulse(input logic e);
        cyc(1);
        loop_status.ref_switched = 1'b1;
        cyc(1);
        loop_status.ref_switched = 1'b0;
        chk("phase_realign", 16'(e), 16'(phase_realign));
    endtask
    task automatic t_defaults;
        chk("tx_mode", 16'(MODE_HOLDOVER), 16'(tx_mode));
        chk("hold", 16'h0001, 16'(hold));
        chk("oe_n", 16'h0002, 16'(diff_driver_oe_n));
        chk("clk0_mult", 16'(1544 / 8), 16'(synth_cfg.clk0_mult));
        chk("clk1_factor", 16'(3088 / 1544), 16'(synth_cfg.clk1_factor));
        chk("clk1_div", 16'h0000, 16'(synth_cfg.clk1_div));
        chk("fp1_rate", 16'(FP1_RATE_8K), 16'(synth_cfg.fp1_rate));
    endtask
    task automatic t_reg_modes;
        logic [DATA_W-1:0] d;
        for (int m = 0; m < 4; m++) begin
            wr(TX_MODE_SEL_ADDR, 8'(m));
            cyc(1);
            chk("tx_mode", 16'(m), 16'(tx_mode));
            chk("hold", 16'(m == MODE_HOLDOVER), 16'(hold));
            rd(TX_MODE_SEL_ADDR, d);
            chk("mode_reg", 16'(m), 16'(d[1:0]));
        end
        wr(TX_MODE_SEL_ADDR, 8'(MODE_AUTOMATIC));
        loop_status.in_holdover = 1'b1;
        cyc(2);
        chk("hold", 16'h0001, 16'(hold));
        loop_status.in_holdover = 1'b0;
        rd(7'h00, d);
        chk("unmapped", 16'h0000, 16'(d));
    endtask
    task automatic t_pin_modes;
        for (int m = 3; m >= 0; m--) begin
            want_mode = 2'(m);
            cyc(8);
            chk("tx_mode", 16'(m), 16'(tx_mode));
        end
        want_mode = MODE_NORMAL;
        cyc(8);
    endtask
    task automatic t_hitless;
        pulse(1'b0);
        want_hs = 1'b0;
        cyc(8);
        chk("hitless_active", 16'h0000, 16'(hitless_active));
        pulse(1'b1);
        wr(HITLESS_CTRL_ADDR, 8'h03);
        cyc(1);
        chk("hitless_active", 16'h0001, 16'(hitless_active));
        pulse(1'b0);
        wr(HITLESS_CTRL_ADDR, 8'h00);
    endtask
    task automatic t_status;
        for (int i = 0; i < 4; i++) begin
            {loop_status.freq_locked, loop_status.phase_locked} = 2'(i);
            rx_ref_selected = i[0];
            cyc(1);
            chk("lock", 16'(i == 3), 16'(lock));
            chk("ref_out", 16'(i[0]), 16'(ref_out));
        end
        {want_d0, want_d1} = 2'h1;
        cyc(8);
        chk("oe_n", 16'h0001, 16'(diff_driver_oe_n));
    endtask
    task automatic t_synth;
        logic [DATA_W-1:0] d;
        wr(FP1_CFG_ADDR, 8'h1D);
        cyc(1);
        chk("fp1_rate", 16'h0001, 16'(synth_cfg.fp1_rate));
        chk("fp1_width", 16'h0003, 16'(synth_cfg.fp1_width));
        chk("fp1_pol", 16'h0001, 16'(synth_cfg.fp1_pol));
        wr(CLK0_LO_ADDR, 8'hE8);
        wr(CLK0_HI_ADDR, 8'h03);
        cyc(1);
        chk("clk0_mult", 16'(8000 / 8), 16'(synth_cfg.clk0_mult));
        wr(CLK0_LO_ADDR, 8'hFF);
        wr(CLK0_HI_ADDR, 8'h3F);
        cyc(1);
        chk("clk0_mult", 16'(8000 / 8), 16'(synth_cfg.clk0_mult));
        rd(CLK0_LO_ADDR, d);
        chk("clk0_lo", 16'h00E8, 16'(d));
        wr(CLK1_CFG_ADDR, 8'h84);
        cyc(1);
        chk("clk1_div", 16'h0001, 16'(synth_cfg.clk1_div));
        chk("clk1_factor", 16'h0004, 16'(synth_cfg.clk1_factor));
        wr(CLK1_CFG_ADDR, 8'h7F);
        cyc(1);
        chk("clk1_div", 16'h0001, 16'(synth_cfg.clk1_div));
        chk("clk1_factor", 16'h0004, 16'(synth_cfg.clk1_factor));
        rd(STATUS_ADDR, d);
        chk("status", 16'h0049, 16'(d));
    endtask
    task automatic t_mid_reset;
        rst_req = 1'b1;
        cyc(1);
        rst_req = 1'b0;
        cyc(2);
        chk("oe_n", 16'h0003, 16'(diff_driver_oe_n));
        chk("lock", 16'h0000, 16'(lock));
        cyc(12);
        chk("tx_mode", 16'(MODE_NORMAL), 16'(tx_mode));
        chk("clk0_mult", 16'(1544 / 8), 16'(synth_cfg.clk0_mult));
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        cyc(12);
        t_defaults();
        t_reg_modes();
        t_pin_modes();
        t_hitless();
        t_status();
        t_synth();
        t_mid_reset();
        end_of_test();
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule
